/* rtl/acr_defs.svh */
// Constants for the auxiliary control register block.
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
`define ACR_OFF_AUX 8'ha2
`define ACR_OFF_PTR_LO 8'ha4
`define ACR_OFF_PTR_HI 8'ha8
`define ACR_OFF_PTR_CMD 8'hac
`define ACR_OFF_STATUS 8'hb0
`define ACR_BIT_PSEL 0
`define ACR_BIT_SPARE 1
`define ACR_BIT_ZERO 2
`define ACR_BIT_SOFT_RST 3
`define ACR_BIT_T0_TGL 4
`define ACR_BIT_T1_TGL 5
`define ACR_BIT_BRK_RST 6
`define ACR_BIT_LOW_PWR 7
`define ACR_AUX_RESET 8'h00
`define ACR_AUX_WMASK 8'hfb
`define ACR_CMD_INC 2'h1
`define ACR_CMD_LOAD 2'h2
`define ACR_RST_PULSE 4'h4
`define ACR_RESP_OKAY 2'h0
`define ACR_RESP_SLVERR 2'h2
`endif

/* rtl/acr_pkg.sv */
// Types shared by the auxiliary control register block.
package acr_pkg;
  typedef enum logic [2:0] {
    ACR_IDLE = 3'h1,
    ACR_WRESP = 3'h2,
    ACR_RRESP = 3'h4
  } acr_bus_t;
endpackage

/* rtl/acr_ptr_bank.sv */
// Two 16-bit data pointers with a registered read of the selected one.
module acr_ptr_bank (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_sel,
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic i_inc,
  input wire logic i_load,
  input wire logic [7:0] i_byte,
  input wire logic [15:0] i_word,
  // Selected pointer
  output logic [15:0] o_ptr
);
  typedef struct packed {
    logic [15:0] p0;
    logic [15:0] p1;
    logic [15:0] rd;
  } acr_bank_t;
  acr_bank_t st, next_st;
  logic [15:0] cur;
  always_comb begin
    next_st = st;
    cur = i_sel ? st.p1 : st.p0;
    // Byte access to selected pointer only.
    if (i_wr_lo) begin
      cur = {cur[15:8], i_byte};
    end
    if (i_wr_hi) begin
      cur = {i_byte, cur[7:0]};
    end
    // Increment and load use selected pointer.
    if (i_inc) begin
      cur = cur + 16'h0001;
    end
    if (i_load) begin
      cur = i_word;
    end
    if (i_sel) begin
      next_st.p1 = cur;
    end else begin
      next_st.p0 = cur;
    end
    next_st.rd = cur;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_ptr = st.rd;
endmodule

/* rtl/acr_aux_ctrl.sv */
// Auxiliary control register with dual pointers, AXI4-Lite slave.
// Notes on behaviour
// - Bit 0 selects the active data pointer.
// - Bit 1 unused; writing one is harmless.
// - Bit 2 reads zero; increment flips select (nothing here increments this register).
// - Writing bit 3 resets the whole chip.
// - Bit 4 toggles timer zero pin per overflow.
// - Bit 5 toggles timer one pin per overflow.
// - Bit 6 lets break force programming reset.
// - Bit 7 selects low power clocks; resets clear.
// - Unselected pointer is unreachable by software.
// - Pointer instructions use the selected pointer.
// - Byte accesses hit selected pointer only.
`include "acr_defs.svh"
module acr_aux_ctrl (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // AXI4-Lite write address and data
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // AXI4-Lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Core pointer operations
  input wire logic i_core_inc,
  input wire logic i_core_load,
  input wire logic [15:0] i_core_word,
  output logic [15:0] o_core_ptr,
  // Timer overflow and UART break events
  input wire logic i_t0_ovf,
  input wire logic i_t1_ovf,
  input wire logic i_uart_break,
  // Pins and chip controls
  output logic o_timer_zero_toggle_pin,
  output logic o_timer_one_toggle_pin,
  output logic o_clock_low_power,
  output logic o_chip_reset,
  output logic o_in_system_programming_mode
);
  typedef struct packed {
    acr_pkg::acr_bus_t bus;
    logic [7:0] aux;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic t0_pin;
    logic t1_pin;
    logic [3:0] rst_cnt;
    logic prog;
  } acr_state_t;
  acr_state_t st, next_st;
  logic ev_t0_s1, ev_t0_s2, ev_t1_s1, ev_t1_s2, brk_s1, brk_s2;
  logic t0_prev, t1_prev;
  logic pb_wr_lo, pb_wr_hi, pb_inc, pb_load;
  logic [7:0] pb_byte;
  logic [15:0] pb_word;
  logic [15:0] sel_ptr;

  // Register offsets are decoded on the word address.
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
    is_reg = (a[7:2] == r[7:2]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = is_reg(a, `ACR_OFF_AUX) | is_reg(a, `ACR_OFF_PTR_LO) |
             is_reg(a, `ACR_OFF_PTR_HI) | is_reg(a, `ACR_OFF_PTR_CMD) |
             is_reg(a, `ACR_OFF_STATUS);
  endfunction

  // Timer and break events come from other blocks on their own pins.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ev_t0_s1 <= 1'b0;
      ev_t0_s2 <= 1'b0;
      ev_t1_s1 <= 1'b0;
      ev_t1_s2 <= 1'b0;
      brk_s1 <= 1'b0;
      brk_s2 <= 1'b0;
      t0_prev <= 1'b0;
      t1_prev <= 1'b0;
    end else begin
      ev_t0_s1 <= i_t0_ovf;
      ev_t0_s2 <= ev_t0_s1;
      ev_t1_s1 <= i_t1_ovf;
      ev_t1_s2 <= ev_t1_s1;
      brk_s1 <= i_uart_break;
      brk_s2 <= brk_s1;
      t0_prev <= ev_t0_s2;
      t1_prev <= ev_t1_s2;
    end
  end

  logic aw_fire, w_fire, do_write, ar_fire;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic t0_edge, t1_edge;

  assign o_awready = (st.bus == acr_pkg::ACR_IDLE) && !st.aw_got;
  assign o_wready = (st.bus == acr_pkg::ACR_IDLE) && !st.w_got;
  assign o_arready = (st.bus == acr_pkg::ACR_IDLE) && !(st.aw_got || st.w_got)
                     && !(i_awvalid || i_wvalid);
  assign aw_fire = i_awvalid && o_awready;
  assign w_fire = i_wvalid && o_wready;
  assign ar_fire = i_arvalid && o_arready;
  assign do_write = (st.aw_got || aw_fire) && (st.w_got || w_fire);
  assign wa = st.aw_got ? st.awaddr : i_awaddr;
  assign wd = st.w_got ? st.wdata : i_wdata;
  assign ws = st.w_got ? st.wstrb : i_wstrb;
  assign t0_edge = ev_t0_s2 && !t0_prev;
  assign t1_edge = ev_t1_s2 && !t1_prev;

  // Pointer bank steering; a software write and a core operation share
  // one cycle, the core's operation being applied after the byte write.
  always_comb begin
    pb_wr_lo = do_write && ws[0] && is_reg(wa, `ACR_OFF_PTR_LO);
    pb_wr_hi = do_write && ws[0] && is_reg(wa, `ACR_OFF_PTR_HI);
    pb_byte = wd[7:0];
    pb_inc = i_core_inc ||
             (do_write && ws[0] && is_reg(wa, `ACR_OFF_PTR_CMD) &&
              wd[1:0] == `ACR_CMD_INC);
    pb_load = i_core_load ||
              (do_write && ws[0] && ws[1] &&
               is_reg(wa, `ACR_OFF_PTR_CMD) && wd[1:0] == `ACR_CMD_LOAD);
    pb_word = i_core_load ? i_core_word : wd[31:16];
  end

  // Select bit steers the pointer bank.
  acr_ptr_bank u_ptr (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_sel(st.aux[`ACR_BIT_PSEL]),
    .i_wr_lo(pb_wr_lo),
    .i_wr_hi(pb_wr_hi),
    .i_inc(pb_inc),
    .i_load(pb_load),
    .i_byte(pb_byte),
    .i_word(pb_word),
    .o_ptr(sel_ptr)
  );

  always_comb begin
    next_st = st;
    if (st.rst_cnt != 4'h0) begin
      next_st.rst_cnt = st.rst_cnt - 4'h1;
    end
    if (aw_fire && !do_write) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = i_awaddr;
    end
    if (w_fire && !do_write) begin
      next_st.w_got = 1'b1;
      next_st.wdata = i_wdata;
      next_st.wstrb = i_wstrb;
    end
    case (st.bus)
      acr_pkg::ACR_IDLE: begin
        if (do_write) begin
          next_st.aw_got = 1'b0;
          next_st.w_got = 1'b0;
          next_st.bus = acr_pkg::ACR_WRESP;
          next_st.bresp = mapped(wa) ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
          if (is_reg(wa, `ACR_OFF_AUX) && ws[0]) begin
            // Spare bit stored, bit 2 forced zero.
            next_st.aux = wd[7:0] & `ACR_AUX_WMASK;
            // Bit 3 written as one resets chip.
            if (wd[`ACR_BIT_SOFT_RST]) begin
              next_st.rst_cnt = `ACR_RST_PULSE;
            end
          end
        end else if (ar_fire) begin
          next_st.bus = acr_pkg::ACR_RRESP;
          next_st.rresp = mapped(i_araddr) ? `ACR_RESP_OKAY
                                           : `ACR_RESP_SLVERR;
          next_st.rdata = 32'h0000_0000;
          if (is_reg(i_araddr, `ACR_OFF_AUX)) begin
            next_st.rdata = {24'h00_0000, st.aux};
          end
          // Only the selected pointer is readable.
          if (is_reg(i_araddr, `ACR_OFF_PTR_LO)) begin
            next_st.rdata = {24'h00_0000, sel_ptr[7:0]};
          end
          if (is_reg(i_araddr, `ACR_OFF_PTR_HI)) begin
            next_st.rdata = {24'h00_0000, sel_ptr[15:8]};
          end
          if (is_reg(i_araddr, `ACR_OFF_STATUS)) begin
            next_st.rdata = {29'h0000_0000, st.prog, st.t1_pin, st.t0_pin};
          end
        end
      end
      acr_pkg::ACR_WRESP: begin
        if (i_bready) begin
          next_st.bus = acr_pkg::ACR_IDLE;
        end
      end
      acr_pkg::ACR_RRESP: begin
        if (i_rready) begin
          next_st.bus = acr_pkg::ACR_IDLE;
        end
      end
      default: begin
        next_st.bus = acr_pkg::ACR_IDLE;
      end
    endcase
    // Timer zero overflow toggles its pin.
    if (st.aux[`ACR_BIT_T0_TGL] && t0_edge) begin
      next_st.t0_pin = !st.t0_pin;
    end
    // Timer one overflow toggles its pin.
    if (st.aux[`ACR_BIT_T1_TGL] && t1_edge) begin
      next_st.t1_pin = !st.t1_pin;
    end
    // A break held high restarts the pulse every cycle, so the reset
    // lasts as long as the break plus three cycles, one less than a full pulse.
    // Enabled break forces programming reset.
    if (st.aux[`ACR_BIT_BRK_RST] && brk_s2) begin
      next_st.rst_cnt = `ACR_RST_PULSE;
      next_st.prog = 1'b1;
    end
  end

  // The software reset is a pulse handed to the chip reset generator,
  // which is expected to bring i_rst back and clear this register too.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.bus <= acr_pkg::ACR_IDLE;
      // Reset clears the low power bit.
      st.aux <= `ACR_AUX_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_bresp = st.bresp;
  assign o_bvalid = (st.bus == acr_pkg::ACR_WRESP);
  assign o_rdata = st.rdata;
  assign o_rresp = st.rresp;
  assign o_rvalid = (st.bus == acr_pkg::ACR_RRESP);
  assign o_core_ptr = sel_ptr;
  assign o_timer_zero_toggle_pin = st.t0_pin;
  assign o_timer_one_toggle_pin = st.t1_pin;
  // Bit 7 drives the low power clock select.
  assign o_clock_low_power = st.aux[`ACR_BIT_LOW_PWR];
  assign o_chip_reset = (st.rst_cnt != 4'h0);
  assign o_in_system_programming_mode = st.prog;

  // Events are seen after the two synchroniser stages, so a pin pulse
  // reaches these checks two cycles after it arrives at the block.
  AST_ZERO_BIT: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    st.aux[`ACR_BIT_ZERO] == 1'b0)
    else $error("Bit 2 of the control register is not zero.");
  AST_AUX_WR: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (do_write && st.bus == acr_pkg::ACR_IDLE && ws[0] &&
     is_reg(wa, `ACR_OFF_AUX)) |=>
    (st.aux[`ACR_BIT_SPARE] == $past(wd[`ACR_BIT_SPARE])))
    else $error("Spare bit did not keep the written value.");
  AST_SOFT_RST: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (do_write && st.bus == acr_pkg::ACR_IDLE && ws[0] &&
     is_reg(wa, `ACR_OFF_AUX) && wd[`ACR_BIT_SOFT_RST])
    |=> o_chip_reset [*4])
    else $error("Software reset pulse missing.");
  AST_T0: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (st.aux[`ACR_BIT_T0_TGL] && t0_edge) |=>
    (o_timer_zero_toggle_pin != $past(o_timer_zero_toggle_pin)))
    else $error("Timer zero pin did not toggle.");
  AST_T0_HOLD: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !(st.aux[`ACR_BIT_T0_TGL] && t0_edge) |=> $stable(st.t0_pin))
    else $error("Timer zero pin moved without overflow.");
  AST_T1: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (st.aux[`ACR_BIT_T1_TGL] && t1_edge) |=>
    (o_timer_one_toggle_pin != $past(o_timer_one_toggle_pin)))
    else $error("Timer one pin did not toggle.");
  AST_T1_HOLD: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    !(st.aux[`ACR_BIT_T1_TGL] && t1_edge) |=> $stable(st.t1_pin))
    else $error("Timer one pin moved without overflow.");
  AST_BRK: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (st.aux[`ACR_BIT_BRK_RST] && brk_s2) |=>
    (o_chip_reset && o_in_system_programming_mode))
    else $error("Break did not force programming reset.");
  AST_NOBRK: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (!st.aux[`ACR_BIT_BRK_RST] && !o_in_system_programming_mode) |=>
    !o_in_system_programming_mode)
    else $error("Programming mode set without break enable.");
  AST_LOW_PWR: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (do_write && st.bus == acr_pkg::ACR_IDLE && ws[0] &&
     is_reg(wa, `ACR_OFF_AUX)) |=>
    (o_clock_low_power == $past(wd[`ACR_BIT_LOW_PWR])))
    else $error("Low power output differs from the written bit 7.");
  AST_INC: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_core_inc && !pb_load && !pb_wr_lo && !pb_wr_hi &&
     $stable(st.aux[`ACR_BIT_PSEL])) |=>
    (o_core_ptr == $past(o_core_ptr) + 16'h0001))
    else $error("Selected pointer did not increment.");
  AST_KEEP: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (!pb_inc && !pb_load && !pb_wr_lo && !pb_wr_hi &&
     $stable(st.aux[`ACR_BIT_PSEL])) |=> $stable(o_core_ptr))
    else $error("Pointer changed without an operation.");
  AST_BVALID: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (do_write && st.bus == acr_pkg::ACR_IDLE) |=> o_bvalid)
    else $error("Write response not raised.");
  AST_RVALID: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ar_fire && !do_write && st.bus == acr_pkg::ACR_IDLE) |=> o_rvalid)
    else $error("Read response not raised.");
  AST_RD_LO: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ar_fire && is_reg(i_araddr, `ACR_OFF_PTR_LO)) |=>
    (o_rdata == {24'h00_0000, $past(o_core_ptr[7:0])}))
    else $error("Low byte read is not from the selected pointer.");
  AST_RD_HI: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (ar_fire && is_reg(i_araddr, `ACR_OFF_PTR_HI)) |=>
    (o_rdata == {24'h00_0000, $past(o_core_ptr[15:8])}))
    else $error("High byte read is not from the selected pointer.");
  COV_SOFT_RST: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_chip_reset));
  COV_T0: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    $changed(o_timer_zero_toggle_pin));
  COV_PROG: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_in_system_programming_mode));
  COV_SWAP: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    $changed(st.aux[`ACR_BIT_PSEL]));
  COV_CMD: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    do_write && is_reg(wa, `ACR_OFF_PTR_CMD));
endmodule

/* tb/acr_core_model.sv */
// Behavioural core that issues data pointer instructions to the block.
module acr_core_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Instruction request from the bench
  input wire logic [1:0] i_op,
  input wire logic [15:0] i_val,
  // Pointer operations towards the block
  output logic o_core_inc,
  output logic o_core_load,
  output logic [15:0] o_core_word
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_core_inc <= 1'b0;
      o_core_load <= 1'b0;
      o_core_word <= 16'h0000;
    end else begin
      o_core_inc <= (i_op == 2'h1);
      o_core_load <= (i_op == 2'h2);
      // The word churns when no load is on, so a stale value never helps.
      o_core_word <= (i_op == 2'h2) ? i_val : ~o_core_word;
    end
  end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the auxiliary control register block.
`include "acr_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, lf, q;
  logic [3:0] i_wstrb;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, sel;
  logic [1:0] o_bresp, o_rresp, op, r;
  logic inc, load, i_t0_ovf, i_t1_ovf, i_uart_break;
  logic [15:0] word, o_core_ptr, val;
  logic t0p, t1p, lp, crst, prog;
  logic [15:0] exp_ptr [2];
  int miscompares, n_checks, rst_cnt;

  acr_aux_ctrl i_acr_aux_ctrl (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .i_core_inc(inc),
    .i_core_load(load), .i_core_word(word), .o_core_ptr(o_core_ptr),
    .i_t0_ovf(i_t0_ovf), .i_t1_ovf(i_t1_ovf), .i_uart_break(i_uart_break),
    .o_timer_zero_toggle_pin(t0p), .o_timer_one_toggle_pin(t1p),
    .o_clock_low_power(lp), .o_chip_reset(crst),
    .o_in_system_programming_mode(prog));
  acr_core_model i_acr_core_model (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_op(op), .i_val(val), .o_core_inc(inc), .o_core_load(load),
    .o_core_word(word));

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // Counted mid-cycle, where the registered reset request has settled.
  always @(negedge i_sys_clk) begin
    if (crst === 1'b1) rst_cnt++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic print_verdict;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // Readys are looked at mid-cycle; the transfer is the next rising edge.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    logic pa, pw, ta, tw;
    @(posedge i_sys_clk);
    if (wr) begin
      i_awaddr <= a;
      i_awvalid <= 1'b1;
      i_wdata <= d;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
    end else begin
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
    end
    pa = 1'b1;
    pw = wr;
    while (pa || pw) begin
      @(negedge i_sys_clk);
      ta = pa && ((wr ? o_awready : o_arready) === 1'b1);
      tw = pw && (o_wready === 1'b1);
      @(posedge i_sys_clk);
      if (ta) begin
        pa = 1'b0;
        if (wr) i_awvalid <= 1'b0;
        else i_arvalid <= 1'b0;
      end
      if (tw) begin
        pw = 1'b0;
        i_wvalid <= 1'b0;
      end
    end
    do @(negedge i_sys_clk); while ((wr ? o_bvalid : o_rvalid) !== 1'b1);
    q = o_rdata;
    r = wr ? o_bresp : o_rresp;
    @(posedge i_sys_clk);
    i_bready <= 1'b0;
    i_rready <= 1'b0;
  endtask

  task automatic aux_wr(input logic [7:0] v);
    bus(1'b1, `ACR_OFF_AUX, {24'h0, v});
    chk("bresp", `ACR_RESP_OKAY, r);
    sel = v[0];
  endtask

  task automatic ptr_op(input logic [1:0] k, input logic [15:0] v);
    if (k < 2'h2) begin
      @(posedge i_sys_clk);
      op <= k + 2'h1;
      val <= v;
      @(posedge i_sys_clk);
      op <= 2'h0;
    end
    case (k)
      2'h0: exp_ptr[sel] = exp_ptr[sel] + 16'h1;
      2'h1: exp_ptr[sel] = v;
      2'h2: begin
        bus(1'b1, `ACR_OFF_PTR_LO, {24'h0, v[7:0]});
        exp_ptr[sel][7:0] = v[7:0];
      end
      default: begin
        bus(1'b1, `ACR_OFF_PTR_HI, {24'h0, v[7:0]});
        exp_ptr[sel][15:8] = v[7:0];
      end
    endcase
    repeat (4) @(posedge i_sys_clk);
    chk("ptr", exp_ptr[sel], o_core_ptr);
  endtask

  task automatic pulse(input int w, input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      if (w == 0) i_t0_ovf <= 1'b1;
      else if (w == 1) i_t1_ovf <= 1'b1;
      else i_uart_break <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      {i_t0_ovf, i_t1_ovf, i_uart_break} <= 3'h0;
      repeat (2) @(posedge i_sys_clk);
    end
    repeat (8) @(posedge i_sys_clk);
  endtask

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    miscompares++;
    print_verdict;
  end

  initial begin
    {i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h20;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = 52'h0000000000000f;
    {i_t0_ovf, i_t1_ovf, i_uart_break, op, val} = 21'h0;
    lf = 32'h0001_6d19;
    exp_ptr = '{16'h0000, 16'h0000};
    sel = 1'b0;
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    bus(1'b0, `ACR_OFF_AUX, 32'h0);
    chk("aux_reset", 32'h0, q);
    aux_wr(8'hb7);
    bus(1'b0, `ACR_OFF_AUX, 32'h0);
    chk("aux_rd", 32'hb3, q);
    chk("low_power", 32'h1, lp);
    ptr_op(2'h1, 16'hffff);
    ptr_op(2'h0, 16'h0);
    repeat (24) begin
      lf = lfsr(lf);
      if (lf[4]) begin
        aux_wr({7'h0, lf[0]});
        repeat (4) @(posedge i_sys_clk);
        chk("ptr_sel", exp_ptr[sel], o_core_ptr);
      end
      ptr_op(lf[3:2], lf[31:16]);
    end
    // Bus pointer commands: load a random word, then step it by one.
    bus(1'b1, `ACR_OFF_PTR_CMD, {lf[15:0], 14'h0000, `ACR_CMD_LOAD});
    bus(1'b1, `ACR_OFF_PTR_CMD, {16'h0000, 14'h0000, `ACR_CMD_INC});
    exp_ptr[sel] = lf[15:0] + 16'h0001;
    repeat (4) @(posedge i_sys_clk);
    chk("ptr_cmd", exp_ptr[sel], o_core_ptr);
    bus(1'b0, `ACR_OFF_PTR_LO, 32'h0);
    chk("ptr_lo_rd", exp_ptr[sel][7:0], q);
    bus(1'b0, `ACR_OFF_PTR_HI, 32'h0);
    chk("ptr_hi_rd", exp_ptr[sel][15:8], q);
    aux_wr(8'h33);
    aux_wr(8'h34);
    bus(1'b0, `ACR_OFF_AUX, 32'h0);
    chk("aux_inc", 32'h30, q);
    aux_wr(8'h10);
    pulse(0, 3);
    pulse(1, 3);
    chk("t0_pin", 32'h1, t0p);
    chk("t1_pin", 32'h0, t1p);
    aux_wr(8'h20);
    pulse(1, 1);
    bus(1'b0, `ACR_OFF_STATUS, 32'h0);
    chk("status", 32'h3, q);
    aux_wr(8'h00);
    rst_cnt = 0;
    pulse(2, 1);
    chk("brk_off", 32'h0, rst_cnt);
    chk("prog_off", 32'h0, prog);
    aux_wr(8'h40);
    rst_cnt = 0;
    pulse(2, 1);
    // The break stays up two cycles and restarts the pulse in each.
    chk("brk_rst", `ACR_RST_PULSE + 32'h1, rst_cnt);
    chk("prog_on", 32'h1, prog);
    rst_cnt = 0;
    aux_wr(8'h08);
    repeat (12) @(posedge i_sys_clk);
    chk("soft_rst", `ACR_RST_PULSE, rst_cnt);
    // The bench stands in for the chip reset generator here.
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    bus(1'b0, `ACR_OFF_AUX, 32'h0);
    chk("aux_init", 32'h0, q);
    chk("ptr_init", 32'h0, o_core_ptr);
    chk("lp_init", 32'h0, lp);
    chk("prog_init", 32'h0, prog);
    bus(1'b0, 8'h80, 32'h0);
    chk("rresp", `ACR_RESP_SLVERR, r);
    chk("unmapped", 32'h0, q);
    print_verdict;
  end
endmodule
